// ===== design/gp_pkg.sv
// package: register map, field layout, reset values and codes for the gpio block
package gp_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int NUM_PORTS     = 4;    // four ports of eight pins, 32 pins
  localparam int PINS_PER_PORT = 8;
  localparam int NUM_PINS      = NUM_PORTS * PINS_PER_PORT;
  localparam int RUN_SLOTS     = 16;   // active-mode alternate function slots
  localparam int SLP_SLOTS     = 8;    // deep-sleep alternate function slots
  localparam int ADDR_W        = 8;

  // ****************************************************************
  // register offsets inside one port window (port base = port * 0x40)
  // ****************************************************************
  localparam logic [5:0] OFS_OUT_DATA  = 6'h00; // output data, rw
  localparam logic [5:0] OFS_PIN_STATE = 6'h04; // sampled pin levels, ro
  localparam logic [5:0] OFS_DRIVE     = 6'h08; // 3-bit drive mode per pin
  localparam logic [5:0] OFS_SLEW      = 6'h0C; // 1 = slow edges
  localparam logic [5:0] OFS_HOLD      = 6'h10; // 1 = freeze pin in sleep
  localparam logic [5:0] OFS_INT_EN    = 6'h14; // interrupt enable
  localparam logic [5:0] OFS_INT_FLAG  = 6'h18; // sticky flags, write 1 clears
  localparam logic [5:0] OFS_FUNC_LO   = 6'h1C; // function select, pins 0..3
  localparam logic [5:0] OFS_FUNC_HI   = 6'h20; // function select, pins 4..7

  // ****************************************************************
  // function select byte: [7:6] kind, [3:0] slot
  // ****************************************************************
  localparam int FSEL_KIND_POS = 6;
  localparam int FSEL_SLOT_POS = 0;
  localparam int FSEL_W        = 8;

  typedef enum logic [1:0] {
    GP_FN_GPIO   = 2'h0,
    GP_FN_ANALOG = 2'h1,
    GP_FN_ACTIVE = 2'h2,
    GP_FN_DEEP   = 2'h3
  } gp_fn_kind_t;

  typedef enum logic [2:0] {
    GP_DM_ANALOG    = 3'h0,
    GP_DM_INPUT     = 3'h1,
    GP_DM_WEAKUP    = 3'h2,
    GP_DM_WEAKDOWN  = 3'h3,
    GP_DM_OD_LOW    = 3'h4,
    GP_DM_OD_HIGH   = 3'h5,
    GP_DM_STRONG    = 3'h6,
    GP_DM_WEAK_BOTH = 3'h7
  } gp_drive_t;

  // ****************************************************************
  // reset values: every pin analog, buffers off
  // ****************************************************************
  localparam logic [7:0]  RST_OUT_DATA = 8'h00;
  localparam logic [23:0] RST_DRIVE    = 24'h00_0000;
  localparam logic [7:0]  RST_SLEW     = 8'h00;
  localparam logic [7:0]  RST_HOLD     = 8'h00;
  localparam logic [7:0]  RST_INT_EN   = 8'h00;
  localparam logic [31:0] RST_FUNC     = 32'h4040_4040;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ===== design/gp_gpio_top.sv
// gpio block: 32 pins in four ports, drive modes, hold, slew, pin mux, irqs
// Functional notes
// - there are 32 pins grouped as four ports of eight, each port one unit.
// - each pin has eight drive modes from analog off through weak both ways.
// - a hold bit freezes the pin's drive while the system sleeps.
// - a slew bit per pin lets software slow the output edges.
// - each port has an output data register and a pin state register.
// - enabled pin events combine into one interrupt request per port.
// - after any reset every pin is analog with both buffers off.
// - a per-pin selector picks which peripheral or analog signal reaches it.
// - the selector offers analog, active slots and deep-sleep slots.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module gp_gpio_top
  import gp_pkg::*;
(
  input  wire logic                               clock,
  input  wire logic                               rst_b,
  input  wire logic [gp_pkg::ADDR_W-1:0]          s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  output logic [1:0]                              s_axi_bresp,
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [gp_pkg::ADDR_W-1:0]          s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  output logic [31:0]                             s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  input  wire logic                               deep_sleep,
  input  wire logic [gp_pkg::NUM_PINS*gp_pkg::RUN_SLOTS-1:0] run_fn_out,
  input  wire logic [gp_pkg::NUM_PINS*gp_pkg::RUN_SLOTS-1:0] run_fn_oe,
  input  wire logic [gp_pkg::NUM_PINS*gp_pkg::SLP_SLOTS-1:0] slp_fn_out,
  input  wire logic [gp_pkg::NUM_PINS*gp_pkg::SLP_SLOTS-1:0] slp_fn_oe,
  output logic [gp_pkg::NUM_PINS-1:0]             fn_in,
  input  wire logic [gp_pkg::NUM_PINS-1:0]        pin_i,
  output logic [gp_pkg::NUM_PINS-1:0]             pin_o,
  output logic [gp_pkg::NUM_PINS-1:0]             pin_oe,
  output logic [gp_pkg::NUM_PINS-1:0]             pin_pull_up,
  output logic [gp_pkg::NUM_PINS-1:0]             pin_pull_down,
  output logic [gp_pkg::NUM_PINS-1:0]             pin_in_en,
  output logic [gp_pkg::NUM_PINS-1:0]             pin_analog_en,
  output logic [gp_pkg::NUM_PINS-1:0]             pin_slow_slew,
  output logic [gp_pkg::NUM_PORTS-1:0]            port_irq
);
  import gp_pkg::*;

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0]          out_ff     [NUM_PORTS];
  logic [23:0]         drive_ff   [NUM_PORTS];
  logic [7:0]          slew_ff    [NUM_PORTS];
  logic [7:0]          hold_ff    [NUM_PORTS];
  logic [7:0]          int_en_ff  [NUM_PORTS];
  logic [7:0]          flag_ff    [NUM_PORTS];
  logic [63:0]         func_ff    [NUM_PORTS];
  logic [NUM_PINS-1:0] sync1_ff;
  logic [NUM_PINS-1:0] sync2_ff;
  logic [NUM_PINS-1:0] sync3_ff;
  logic [NUM_PINS-1:0] state_ff;
  logic [NUM_PINS-1:0] nxt_state;
  logic                aw_ok_ff;
  logic                w_ok_ff;
  logic [ADDR_W-1:0]   waddr_ff;
  logic [31:0]         wdata_ff;
  logic [3:0]          wstrb_ff;
  logic                do_wr;
  logic [1:0]          wport;
  logic [5:0]          wofs;
  logic                wr_hit;
  logic [31:0]         rd_word;
  logic                rd_hit;

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int k = 0; k < 4; k++) begin
      if (strb[k]) begin
        res[k*8 +: 8] = dat[k*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  assign do_wr  = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
  assign wport  = waddr_ff[7:6];
  assign wofs   = waddr_ff[5:0];
  assign wr_hit = (waddr_ff[1:0] == 2'h0) && (wofs <= OFS_FUNC_HI);

  // address and data are taken in either order, response after both
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_ok_ff      <= 1'b0;
      w_ok_ff       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      waddr_ff      <= '0;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff      <= 1'b1;
        waddr_ff      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff      <= 1'b1;
        wdata_ff     <= s_axi_wdata;
        wstrb_ff     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_ok_ff     <= 1'b0;
        w_ok_ff      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // configuration registers, reset to analog with buffers off
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        out_ff[p]    <= RST_OUT_DATA;
        drive_ff[p]  <= RST_DRIVE;
        slew_ff[p]   <= RST_SLEW;
        hold_ff[p]   <= RST_HOLD;
        int_en_ff[p] <= RST_INT_EN;
        func_ff[p]   <= {RST_FUNC, RST_FUNC};
      end
    end else if (do_wr) begin
      unique case (wofs)
        OFS_OUT_DATA: out_ff[wport] <=
          8'(merge({24'h00_0000, out_ff[wport]}, wdata_ff, wstrb_ff));
        OFS_DRIVE: drive_ff[wport] <=
          24'(merge({8'h00, drive_ff[wport]}, wdata_ff, wstrb_ff));
        OFS_SLEW: slew_ff[wport] <=
          8'(merge({24'h00_0000, slew_ff[wport]}, wdata_ff, wstrb_ff));
        OFS_HOLD: hold_ff[wport] <=
          8'(merge({24'h00_0000, hold_ff[wport]}, wdata_ff, wstrb_ff));
        OFS_INT_EN: int_en_ff[wport] <=
          8'(merge({24'h00_0000, int_en_ff[wport]}, wdata_ff, wstrb_ff));
        OFS_FUNC_LO: func_ff[wport][31:0] <=
          merge(func_ff[wport][31:0], wdata_ff, wstrb_ff);
        OFS_FUNC_HI: func_ff[wport][63:32] <=
          merge(func_ff[wport][63:32], wdata_ff, wstrb_ff);
        default: ;                                      // read-only, write-1-clear flags or unmapped
      endcase
    end
  end

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  always_comb begin
    logic [1:0] rp;
    rp      = s_axi_araddr[7:6];
    rd_hit  = (s_axi_araddr[1:0] == 2'h0);
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr[5:0])
      OFS_OUT_DATA:  rd_word[7:0]  = out_ff[rp];
      OFS_PIN_STATE: rd_word[7:0]  = state_ff[rp*8 +: 8];
      OFS_DRIVE:     rd_word[23:0] = drive_ff[rp];
      OFS_SLEW:      rd_word[7:0]  = slew_ff[rp];
      OFS_HOLD:      rd_word[7:0]  = hold_ff[rp];
      OFS_INT_EN:    rd_word[7:0]  = int_en_ff[rp];
      OFS_INT_FLAG:  rd_word[7:0]  = flag_ff[rp];
      OFS_FUNC_LO:   rd_word       = func_ff[rp][31:0];
      OFS_FUNC_HI:   rd_word       = func_ff[rp][63:32];
      default:       rd_hit        = 1'b0;
    endcase
  end

  // one read at a time, answer registered one cycle after address
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // pin input sampling: three stages, accept when stages 2 and 3 agree
  // ****************************************************************
  always_comb begin
    for (int n = 0; n < NUM_PINS; n++) begin
      nxt_state[n] = state_ff[n];
      if (pin_in_en[n] && (sync2_ff[n] == sync3_ff[n])) begin
        nxt_state[n] = sync3_ff[n];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      state_ff <= '0;
      fn_in    <= '0;
    end else begin
      sync1_ff <= pin_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      state_ff <= nxt_state;
      fn_in    <= nxt_state;
    end
  end

  // ****************************************************************
  // sticky pin flags on any edge, set beats clear; port irq
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        flag_ff[p] <= 8'h00;
      end
      port_irq <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        logic [7:0] clr;
        logic [7:0] set;
        clr = (do_wr && wofs == OFS_INT_FLAG && wport == 2'(p) && wstrb_ff[0])
              ? wdata_ff[7:0] : 8'h00;
        set = (nxt_state[p*8 +: 8] ^ state_ff[p*8 +: 8]) & int_en_ff[p];
        flag_ff[p]  <= (flag_ff[p] & ~clr) | set;
        port_irq[p] <= |(((flag_ff[p] & ~clr) | set) & int_en_ff[p]);
      end
    end
  end

  // ****************************************************************
  // per-pin mux and drive stage
  // ****************************************************************
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    localparam int P = i / PINS_PER_PORT;
    localparam int B = i % PINS_PER_PORT;
    gp_fn_kind_t kind;
    gp_drive_t   mode;
    logic [3:0]  slot;
    logic        d;
    logic        en;
    logic        n_o, n_oe, n_pu, n_pd, n_ie, n_an;
    logic        o_ff, oe_ff, pu_ff, pd_ff, ie_ff, an_ff, sl_ff;

    assign kind = gp_fn_kind_t'(func_ff[P][B*FSEL_W+FSEL_KIND_POS +: 2]);
    assign slot = func_ff[P][B*FSEL_W+FSEL_SLOT_POS +: 4];
    assign mode = gp_drive_t'(drive_ff[P][B*3 +: 3]);

    // source selection by function kind
    always_comb begin
      unique case (kind)
        GP_FN_GPIO: begin
          d  = out_ff[P][B];
          en = 1'b1;
        end
        GP_FN_ACTIVE: begin                             // not driven in sleep
          d  = run_fn_out[i*RUN_SLOTS + int'(slot)];
          en = run_fn_oe[i*RUN_SLOTS + int'(slot)] && !deep_sleep;
        end
        GP_FN_DEEP: begin
          d  = slp_fn_out[i*SLP_SLOTS + int'(slot[2:0])];
          en = slp_fn_oe[i*SLP_SLOTS + int'(slot[2:0])];
        end
        GP_FN_ANALOG: begin
          d  = 1'b0;
          en = 1'b0;
        end
      endcase
    end

    // drive mode decode
    always_comb begin
      n_o  = d;
      n_oe = 1'b0;
      n_pu = 1'b0;
      n_pd = 1'b0;
      n_ie = (mode != GP_DM_ANALOG) && (kind != GP_FN_ANALOG);
      n_an = (mode == GP_DM_ANALOG) || (kind == GP_FN_ANALOG);
      unique case (mode)
        GP_DM_ANALOG, GP_DM_INPUT: ;
        GP_DM_WEAKUP: begin
          n_oe = en && !d;
          n_pu = en && d;
        end
        GP_DM_WEAKDOWN: begin
          n_oe = en && d;
          n_pd = en && !d;
        end
        GP_DM_OD_LOW:    n_oe = en && !d;
        GP_DM_OD_HIGH:   n_oe = en && d;
        GP_DM_STRONG:    n_oe = en;
        GP_DM_WEAK_BOTH: begin
          n_pu = en && d;
          n_pd = en && !d;
        end
      endcase
    end

    // output flops, frozen while held in sleep
    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        o_ff  <= 1'b0;
        oe_ff <= 1'b0;
        pu_ff <= 1'b0;
        pd_ff <= 1'b0;
        ie_ff <= 1'b0;
        an_ff <= 1'b1;
        sl_ff <= 1'b0;
      end else if (!(hold_ff[P][B] && deep_sleep)) begin
        o_ff  <= n_o;
        oe_ff <= n_oe;
        pu_ff <= n_pu;
        pd_ff <= n_pd;
        ie_ff <= n_ie;
        an_ff <= n_an;
        sl_ff <= slew_ff[P][B];
      end
    end

    assign pin_o[i]         = o_ff;
    assign pin_oe[i]        = oe_ff;
    assign pin_pull_up[i]   = pu_ff;
    assign pin_pull_down[i] = pd_ff;
    assign pin_in_en[i]     = ie_ff;
    assign pin_analog_en[i] = an_ff;
    assign pin_slow_slew[i] = sl_ff;
  end

endmodule

// ===== tb/gp_gpio_checker.sv
// checker: port-level assertions for the gpio block
`timescale 1ns/1ps
module gp_gpio_checker (
  input wire logic                          clock,
  input wire logic                          rst_b,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic [31:0]                   s_axi_rdata,
  input wire logic                          s_axi_rvalid,
  input wire logic                          s_axi_rready,
  input wire logic [1:0]                    s_axi_bresp,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic                          deep_sleep,
  input wire logic [gp_pkg::NUM_PINS-1:0]   fn_in,
  input wire logic [gp_pkg::NUM_PINS-1:0]   pin_oe,
  input wire logic [gp_pkg::NUM_PINS-1:0]   pin_in_en,
  input wire logic [gp_pkg::NUM_PINS-1:0]   pin_analog_en,
  input wire logic [gp_pkg::NUM_PINS-1:0]   pin_slow_slew,
  input wire logic [gp_pkg::NUM_PORTS-1:0]  port_irq
);
  import gp_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // ****************************************************************
  // bus answers
  // ****************************************************************
  AST_RD_ANSWER:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
  AST_RD_STANDS:
    assert property (s_axi_rvalid && !s_axi_rready
                     |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
  AST_WR_STANDS:
    assert property (s_axi_bvalid && !s_axi_bready
                     |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
  AST_RD_BUSY:
    assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answer pending");
  // ****************************************************************
  // pins and interrupts
  // ****************************************************************
  AST_RESET_ANALOG:
    assert property ($rose(rst_b) |-> (&pin_analog_en) && pin_oe == '0
                     && port_irq == '0)
      else $error("pins not analog after reset");
  AST_ANALOG_OFF:
    assert property ((pin_analog_en & (pin_oe | pin_in_en)) == '0)
      else $error("analog pin has a buffer on");
  AST_IRQ_STICKY:
    assert property (|($past(port_irq) & ~port_irq) |-> $rose(s_axi_bvalid))
      else $error("port irq fell without a write");
  AST_IRQ_CAUSE:
    assert property (|(port_irq & ~$past(port_irq))
                     |-> fn_in != $past(fn_in) || $rose(s_axi_bvalid))
      else $error("port irq rose without a pin event");
  AST_SLEW_WRITE:
    assert property (!$stable(pin_slow_slew) && !$past(deep_sleep)
                     && !$past(deep_sleep, 2) && !$past(deep_sleep, 3)
                     |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
      else $error("slew changed without a write");
  COV_IRQ: cover property ($rose(|port_irq));
  COV_DECERR: cover property (s_axi_bvalid && s_axi_bresp == RESP_DECERR);
  COV_SLEEP: cover property ($rose(deep_sleep));
endmodule
bind gp_gpio_top gp_gpio_checker u_gp_gpio_checker (.clock, .rst_b,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .deep_sleep, .fn_in, .pin_oe,
  .pin_in_en, .pin_analog_en, .pin_slow_slew, .port_irq);

// ===== tb/gp_pins_model.sv
// partner: board-side pin levels seen by the gpio block
`timescale 1ns/1ps
module gp_pins_model (
  input wire logic         clock,
  input wire logic [31:0]  pin_o,
  input wire logic [31:0]  pin_oe,
  input wire logic [31:0]  pin_pull_up,
  input wire logic [31:0]  pin_pull_down,
  input wire logic [31:0]  ext_en,
  input wire logic [31:0]  ext_val,
  output logic [31:0]      pin_i
);
  logic [31:0] tgl_ff = 32'h5555_5555;
  // a line nobody drives or pulls flips every cycle, no stale level
  always @(posedge clock) tgl_ff <= ~tgl_ff;
  // own drive first, then the board source, then the weak pull, then noise
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
               | (~pin_oe & ~ext_en & (pin_pull_up | (~pin_pull_down & tgl_ff)));
endmodule

// ===== tb/test_gpio_port_with_pin_mux.sv
// testbench: bus, drive mode, interrupt, hold and mux checks
`timescale 1ns/1ps
module test_gpio_port_with_pin_mux;
  import gp_pkg::*;
  localparam int AW = gp_pkg::NUM_PINS * gp_pkg::RUN_SLOTS;
  localparam int DW = gp_pkg::NUM_PINS * gp_pkg::SLP_SLOTS;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, deep_sleep = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [AW-1:0] run_fn_out = '0, run_fn_oe = '1;
  logic [DW-1:0] slp_fn_out = '0, slp_fn_oe = '1;
  logic [31:0] fn_in, pin_i, pin_o, pin_oe, pin_pull_up, pin_pull_down;
  logic [31:0] pin_in_en, pin_analog_en, pin_slow_slew, ext_en = 0, ext_val = 0;
  logic [3:0] port_irq;
  logic [31:0] d, v, w, e;
  int miscompares = 0, n_tests = 0, cyc = 0, seed = 88417, i, m, b;
  int t0[8] = '{0, 0, 4, 1, 4, 0, 4, 1}; // oe/up/down by mode, out low
  int t1[8] = '{0, 0, 2, 4, 0, 4, 4, 2}; // same with out high
  int kd[4] = '{2, 2, 3, 3};
  int sl[4] = '{0, 15, 2, 7};
  logic [5:0] ofs[7] = '{OFS_OUT_DATA, OFS_DRIVE, OFS_SLEW, OFS_HOLD,
                         OFS_INT_EN, OFS_FUNC_LO, OFS_FUNC_HI};

  gp_gpio_top u_gp_gpio_top (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .deep_sleep, .run_fn_out, .run_fn_oe, .slp_fn_out, .slp_fn_oe, .fn_in,
    .pin_i, .pin_o, .pin_oe, .pin_pull_up, .pin_pull_down, .pin_in_en,
    .pin_analog_en, .pin_slow_slew, .port_irq);
  gp_pins_model u_gp_pins_model (.clock, .pin_o, .pin_oe, .pin_pull_up,
    .pin_pull_down, .ext_en, .ext_val, .pin_i);

  // 10 MHz clock
  always #50 clock = ~clock;

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  function automatic logic [7:0] ad(input int p, input logic [5:0] o);
    return 8'(p * 64) + {2'b00, o};
  endfunction
  task automatic settle;
    repeat (4) @(posedge clock);
  endtask
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // read: rready held until the answer is sampled
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      conclude();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    for (i = 0; i < 28; i++) begin
      rd(ad(i / 7, ofs[i % 7]));
      chk("reset reg", d, (i % 7) > 4 ? RST_FUNC : 32'h0000_0000);
    end
    chk("analog", pin_analog_en, 32'hffff_ffff);
    chk("oe in", pin_oe | pin_in_en, 32'h0000_0000);
    $display("test reset finished");
    wr(ad(0, OFS_FUNC_LO), 32'h0000_0000);
    for (m = 0; m < 8; m++) begin
      for (b = 0; b < 2; b++) begin
        wr(ad(0, OFS_OUT_DATA), 32'(b));
        wr(ad(0, OFS_DRIVE), 32'(m));
        settle();
        e = 32'(b ? t1[m] : t0[m]);
        chk("drive", {pin_oe[0], pin_pull_up[0], pin_pull_down[0]}, e);
        chk("in_en", pin_in_en[0], 32'(m != 0));
        if (e[2]) chk("pin_o", pin_o[0], 32'(b));
      end
    end
    v = $random(seed);
    wr(ad(0, OFS_FUNC_HI), 32'h0000_0000);
    wr(ad(0, OFS_DRIVE), 32'h00db_6db6);
    wr(ad(0, OFS_OUT_DATA), v);
    wr(ad(0, OFS_SLEW), v >> 8);
    settle();
    chk("out pins", pin_o[7:0], v[7:0]);
    chk("slew", pin_slow_slew[7:0], v[15:8]);
    rd(ad(0, OFS_SLEW));
    chk("slew reg", d, v[15:8]);
    $display("test drive finished");
    // board levels change only every few cycles, well inside the rate limits
    v = $random(seed);
    ext_en[15:8] <= 8'hff;
    ext_val[15:8] <= v[7:0];
    wr(ad(1, OFS_FUNC_LO), 32'h0000_0000);
    wr(ad(1, OFS_FUNC_HI), 32'h0000_0000);
    wr(ad(1, OFS_DRIVE), 32'h0024_9249);
    wr(ad(1, OFS_INT_EN), 32'h0000_000f);
    settle();
    wr(ad(1, OFS_INT_FLAG), 32'h0000_00ff);
    settle();
    chk("irq idle", port_irq, 4'b0000);
    w = v ^ ($random(seed) | 1);
    ext_val[15:8] <= w[7:0];
    repeat (2) settle();
    e = (v ^ w) & 32'h0000_000f;
    chk("irq", port_irq, 4'b0010);
    rd(ad(1, OFS_INT_FLAG));
    chk("flags", d, e);
    rd(ad(1, OFS_PIN_STATE));
    chk("state", d, w[7:0]);
    chk("fn_in", fn_in[15:8], w[7:0]);
    ext_val[15:8] <= w[7:0] ^ 8'hf0;
    repeat (2) settle();
    rd(ad(1, OFS_INT_FLAG));
    chk("sticky", d, e);
    wr(ad(1, OFS_INT_FLAG), e);
    settle();
    chk("irq clear", port_irq, 4'b0000);
    $display("test interrupt finished");
    wr(ad(2, OFS_FUNC_LO), 32'h0000_0000);
    wr(ad(2, OFS_FUNC_HI), 32'h0000_0000);
    wr(ad(2, OFS_DRIVE), 32'h00db_6db6);
    wr(ad(2, OFS_OUT_DATA), 32'h0000_00a5);
    wr(ad(2, OFS_HOLD), 32'h0000_00ff);
    deep_sleep <= 1'b1;
    wr(ad(2, OFS_OUT_DATA), 32'h0000_005a);
    settle();
    chk("held", pin_o[23:16], 8'ha5);
    deep_sleep <= 1'b0;
    settle();
    chk("released", pin_o[23:16], 8'h5a);
    $display("test hold finished");
    for (i = 0; i < 16; i++) run_fn_out[i*32+:32] <= $random(seed);
    for (i = 0; i < 8; i++) slp_fn_out[i*32+:32] <= $random(seed);
    wr(ad(3, OFS_DRIVE), 32'h00db_6db6);
    for (i = 0; i < 4; i++) begin
      deep_sleep <= kd[i] == 3;
      wr(ad(3, OFS_FUNC_LO), 32'(kd[i] * 64 + sl[i]));
      for (b = 0; b < 2; b++) begin
        settle();
        e = 32'(kd[i] == 2 ? run_fn_out[24*16+sl[i]] : slp_fn_out[24*8+sl[i]]);
        chk("slot", pin_o[24], e);
        run_fn_out <= ~run_fn_out;
        slp_fn_out <= ~slp_fn_out;
      end
    end
    deep_sleep <= 1'b0;
    wr(ad(3, OFS_FUNC_LO), 32'h0000_0040);
    settle();
    chk("analog slot", pin_analog_en[24], 1'b1);
    $display("test mux finished");
    rd(ad(0, 6'h3c));
    chk("unmapped rd", d, 32'h0000_0000);
    chk("unmapped rresp", 32'(r), 32'(RESP_DECERR));
    wr(ad(0, 6'h24), 32'hffff_ffff);
    chk("unmapped wr", r, RESP_DECERR);
    wr(ad(0, 6'h01), 32'hffff_ffff);
    chk("misaligned", r, RESP_DECERR);
    wr(ad(1, OFS_PIN_STATE), 32'h0000_0000);
    chk("ro write", r, RESP_OKAY);
    rd(ad(1, OFS_PIN_STATE));
    chk("ro kept", d, w[7:0] ^ 8'hf0);
    $display("test errors finished");
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    chk("reanalog", pin_analog_en, 32'hffff_ffff);
    chk("reoe", pin_oe, 32'h0000_0000);
    rst_b <= 1'b1;
    rd(ad(3, OFS_FUNC_LO));
    chk("refunc", d, RST_FUNC);
    $display("test rereset finished");
    conclude();
  end
endmodule
